// ==== shared/dsdr_pkg.sv ====
package dsdr_pkg;

    // Link timing: the controller divides ref_clk down to make the memory clock.
    localparam int       DSDR_REF_PERIOD_NS  = 10;
    localparam int       DSDR_LINK_PERIOD_NS = 80;
    localparam int       DSDR_LINK_CYCLES    = DSDR_LINK_PERIOD_NS / DSDR_REF_PERIOD_NS;
    localparam int       DSDR_HALF_CYCLES    = DSDR_LINK_CYCLES / 2;
    localparam logic [2:0] DSDR_CNT_FALL     = 3'(DSDR_HALF_CYCLES - 1);
    localparam logic [2:0] DSDR_CNT_RISE     = 3'(DSDR_LINK_CYCLES - 1);

    // Write burst milestones, in ref_clk cycles after the command is driven.
    localparam logic [4:0] DSDR_WR_WORD0_T   = 5'(DSDR_LINK_CYCLES);
    localparam logic [4:0] DSDR_WR_STB_UP_T  = 5'(DSDR_LINK_CYCLES + DSDR_HALF_CYCLES / 2);
    localparam logic [4:0] DSDR_WR_WORD1_T   = 5'(DSDR_LINK_CYCLES + DSDR_HALF_CYCLES);
    localparam logic [4:0] DSDR_WR_STB_DN_T  = 5'(DSDR_LINK_CYCLES + 3 * DSDR_HALF_CYCLES / 2);
    localparam logic [4:0] DSDR_WR_END_T     = 5'(2 * DSDR_LINK_CYCLES);

    // Field positions and sizes.
    localparam int       DSDR_LANES          = 4;
    localparam int       DSDR_AP_BIT         = 10;
    localparam int       DSDR_MEM_WORDS      = 64;

    // Command code {chip select, row strobe, column strobe, write enable}, all active low.
    typedef enum logic [3:0] {
        DSDR_CMD_MRS     = 4'h0,
        DSDR_CMD_REFRESH = 4'h1,
        DSDR_CMD_PRE     = 4'h2,
        DSDR_CMD_ACT     = 4'h3,
        DSDR_CMD_WRITE   = 4'h4,
        DSDR_CMD_READ    = 4'h5,
        DSDR_CMD_BST     = 4'h6,
        DSDR_CMD_NOP     = 4'h7,
        DSDR_CMD_DESEL   = 4'hF
    } dsdr_cmd_type;

    typedef enum {
        DSDR_PWR_RUN,
        DSDR_PWR_PRE_PD,
        DSDR_PWR_ACT_PD,
        DSDR_PWR_SELF
    } dsdr_pwr_type;

    // Everything the device samples from the pins.
    typedef struct packed {
        logic        clk;
        logic        clk_n;
        logic        cke;
        logic [3:0]  cmd;
        logic [1:0]  bank;
        logic [11:0] addr;
        logic [3:0]  mask;
        logic [31:0] dq;
        logic [3:0]  dqs;
    } dsdr_pins_type;

endpackage

// ==== shared/dsdr_link_if.sv ====
`timescale 1ns/1ns
interface dsdr_link_if;
    logic        diff_clock;
    logic        diff_clock_n;
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  bank_select;
    logic [11:0] addr;
    logic [3:0]  write_mask_lanes;
    logic [31:0] ctl_data_out;
    logic        ctl_data_oe;
    logic [31:0] dev_data_out;
    logic        dev_data_oe;
    logic [3:0]  ctl_strobe_out;
    logic        ctl_strobe_oe;
    logic [3:0]  dev_strobe_out;
    logic        dev_strobe_oe;
    logic [31:0] data_bus;
    logic [3:0]  data_strobe_lanes;

    // Bus resolution: the controller wins if both ends enable; an undriven bus reads as zero.
    assign data_bus          = ctl_data_oe ? ctl_data_out :
                               (dev_data_oe ? dev_data_out : 32'h0000_0000);
    assign data_strobe_lanes = ctl_strobe_oe ? ctl_strobe_out :
                               (dev_strobe_oe ? dev_strobe_out : 4'h0);

    modport device (
        input  diff_clock, diff_clock_n, cke, cs_n, ras_n, cas_n, we_n,
        input  bank_select, addr, write_mask_lanes, data_bus, data_strobe_lanes,
        output dev_data_out, dev_data_oe, dev_strobe_out, dev_strobe_oe
    );

    modport controller (
        output diff_clock, diff_clock_n, cke, cs_n, ras_n, cas_n, we_n,
        output bank_select, addr, write_mask_lanes,
        output ctl_data_out, ctl_data_oe, ctl_strobe_out, ctl_strobe_oe,
        input  data_bus, data_strobe_lanes
    );
endinterface

// ==== hdl/dsdr_device.sv ====
`timescale 1ns/1ns
module dsdr_device (
    // Clock, reset and enable.
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Memory link.
    dsdr_link_if.device      link,
    // Status.
    output wire logic        power_down,
    output wire logic        self_refresh,
    output wire logic [3:0]  open_banks
);

    typedef struct packed {
        dsdr_pkg::dsdr_pins_type s1;
        dsdr_pkg::dsdr_pins_type s2;
        logic                    clk_q;
        logic [3:0]              dqs_q;
        dsdr_pkg::dsdr_pwr_type  pwr;
        logic [3:0]              open;
        logic [3:0][11:0]        rows;
        logic                    wr_act;
        logic                    wr_swap;
        logic [5:0]              wr_idx;
        logic [3:0]              got0;
        logic [3:0]              got1;
        logic [63:0]             wbuf;
        logic [7:0]              wmask;
        logic                    commit;
        logic [1:0]              rd_step;
        logic [63:0]             rbuf;
        logic [31:0]             dq_out;
        logic                    dq_oe;
        logic [3:0]              dqs_out;
        logic                    dqs_oe;
        logic                    pd_flag;
        logic                    sr_flag;
    } dsdr_dev_state_type;

    dsdr_dev_state_type st;
    dsdr_dev_state_type next_st;
    logic [63:0]        mem [dsdr_pkg::DSDR_MEM_WORDS];

    logic                   rise;
    logic                   fall;
    dsdr_pkg::dsdr_cmd_type cmd;
    logic [5:0]             idx;
    logic [63:0]            fetched;

    always_comb begin
        next_st = st;
        next_st.s1 = '{clk: link.diff_clock, clk_n: link.diff_clock_n, cke: link.cke,
                      cmd: {link.cs_n, link.ras_n, link.cas_n, link.we_n},
                      bank: link.bank_select, addr: link.addr,
                      mask: link.write_mask_lanes, dq: link.data_bus,
                      dqs: link.data_strobe_lanes};
        next_st.s2 = st.s1;
        next_st.clk_q = st.s2.clk;
        next_st.dqs_q = st.s2.dqs;
        next_st.commit = 1'b0;
        // Edges are found on the synchronised pair, both legs agreeing.
        rise = st.s2.clk & ~st.s2.clk_n & ~st.clk_q;
        fall = ~st.s2.clk & st.s2.clk_n & st.clk_q;
        cmd = dsdr_pkg::dsdr_cmd_type'(st.s2.cmd);
        idx = {st.s2.bank, st.rows[st.s2.bank][0], st.s2.addr[3:1]};
        fetched = mem[idx];

        case (st.pwr)
            dsdr_pkg::DSDR_PWR_RUN: begin
                if (rise && !st.s2.cke) begin
                    if (cmd == dsdr_pkg::DSDR_CMD_REFRESH) begin
                        next_st.pwr = dsdr_pkg::DSDR_PWR_SELF;
                    end else if (|st.open) begin
                        next_st.pwr = dsdr_pkg::DSDR_PWR_ACT_PD;
                    end else begin
                        next_st.pwr = dsdr_pkg::DSDR_PWR_PRE_PD;
                    end
                end else if (rise && !st.s2.cmd[3]) begin
                    case (cmd)
                        dsdr_pkg::DSDR_CMD_ACT: begin
                            next_st.open[st.s2.bank] = 1'b1;
                            next_st.rows[st.s2.bank] = st.s2.addr;
                        end
                        dsdr_pkg::DSDR_CMD_PRE: begin
                            if (st.s2.addr[dsdr_pkg::DSDR_AP_BIT]) begin
                                next_st.open = 4'h0;
                            end else begin
                                next_st.open[st.s2.bank] = 1'b0;
                            end
                        end
                        dsdr_pkg::DSDR_CMD_READ: begin
                            // Both halves come out of the core in one fetch.
                            next_st.rbuf = st.s2.addr[0] ? {fetched[31:0], fetched[63:32]}
                                                         : fetched;
                            next_st.rd_step = 2'h1;
                            next_st.dqs_oe = 1'b1;
                            next_st.dqs_out = 4'h0;
                            if (st.s2.addr[dsdr_pkg::DSDR_AP_BIT]) begin
                                next_st.open[st.s2.bank] = 1'b0;
                            end
                        end
                        dsdr_pkg::DSDR_CMD_WRITE: begin
                            next_st.wr_act = 1'b1;
                            next_st.wr_swap = st.s2.addr[0];
                            next_st.wr_idx = idx;
                            next_st.got0 = 4'h0;
                            next_st.got1 = 4'h0;
                            if (st.s2.addr[dsdr_pkg::DSDR_AP_BIT]) begin
                                next_st.open[st.s2.bank] = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            dsdr_pkg::DSDR_PWR_PRE_PD, dsdr_pkg::DSDR_PWR_ACT_PD: begin
                if (rise && st.s2.cke) begin
                    next_st.pwr = dsdr_pkg::DSDR_PWR_RUN;
                end
            end
            dsdr_pkg::DSDR_PWR_SELF: begin
                // Exit is taken on the enable level alone, no clock edge needed.
                if (st.s2.cke) begin
                    next_st.pwr = dsdr_pkg::DSDR_PWR_RUN;
                end
            end
            default: begin
                next_st.pwr = dsdr_pkg::DSDR_PWR_RUN;
            end
        endcase

        // Read burst: strobe changes together with the data word.
        case (st.rd_step)
            2'h1: begin
                if (rise) begin
                    next_st.dq_out = st.rbuf[31:0];
                    next_st.dq_oe = 1'b1;
                    next_st.dqs_out = 4'hF;
                    next_st.rd_step = 2'h2;
                end
            end
            2'h2: begin
                if (fall) begin
                    next_st.dq_out = st.rbuf[63:32];
                    next_st.dqs_out = 4'h0;
                    next_st.rd_step = 2'h3;
                end
            end
            2'h3: begin
                if (rise) begin
                    next_st.dq_oe = 1'b0;
                    next_st.dqs_oe = 1'b0;
                    next_st.rd_step = 2'h0;
                end
            end
            default: begin
            end
        endcase

        // Write burst: each lane captures its own byte and mask on its own strobe.
        if (st.wr_act) begin
            for (int i = 0; i < dsdr_pkg::DSDR_LANES; i++) begin
                if (st.s2.dqs[i] && !st.dqs_q[i] && !st.got0[i]) begin
                    next_st.wbuf[i*8 +: 8] = st.s2.dq[i*8 +: 8];
                    next_st.wmask[i] = st.s2.mask[i];
                    next_st.got0[i] = 1'b1;
                end else if (!st.s2.dqs[i] && st.dqs_q[i] && st.got0[i] && !st.got1[i]) begin
                    next_st.wbuf[32 + i*8 +: 8] = st.s2.dq[i*8 +: 8];
                    next_st.wmask[4 + i] = st.s2.mask[i];
                    next_st.got1[i] = 1'b1;
                end
            end
            if (&next_st.got1) begin
                next_st.wr_act = 1'b0;
                next_st.commit = 1'b1;
                if (st.wr_swap) begin
                    next_st.wbuf = {next_st.wbuf[31:0], next_st.wbuf[63:32]};
                    next_st.wmask = {next_st.wmask[3:0], next_st.wmask[7:4]};
                end
            end
        end

        // Low enable silences the drivers and drops any burst in flight.
        if (next_st.pwr != dsdr_pkg::DSDR_PWR_RUN) begin
            next_st.dq_oe = 1'b0;
            next_st.dqs_oe = 1'b0;
            next_st.rd_step = 2'h0;
            next_st.wr_act = 1'b0;
        end
        next_st.pd_flag = (next_st.pwr == dsdr_pkg::DSDR_PWR_PRE_PD) ||
                          (next_st.pwr == dsdr_pkg::DSDR_PWR_ACT_PD);
        next_st.sr_flag = (next_st.pwr == dsdr_pkg::DSDR_PWR_SELF);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.pwr <= dsdr_pkg::DSDR_PWR_RUN;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // Core array; masked bytes keep their old contents.
    always_ff @(posedge ref_clk) begin
        if (ce && st.commit) begin
            for (int b = 0; b < 8; b++) begin
                if (!st.wmask[b]) begin
                    mem[st.wr_idx][b*8 +: 8] <= st.wbuf[b*8 +: 8];
                end
            end
        end
    end

    assign link.dev_data_out   = st.dq_out;
    assign link.dev_data_oe    = st.dq_oe;
    assign link.dev_strobe_out = st.dqs_out;
    assign link.dev_strobe_oe  = st.dqs_oe;
    assign power_down          = st.pd_flag;
    assign self_refresh        = st.sr_flag;
    assign open_banks          = st.open;

endmodule

// ==== hdl/dsdr_controller.sv ====
`timescale 1ns/1ns
module dsdr_controller (
    // Clock, reset and enable.
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    // Memory link.
    dsdr_link_if.controller             link,
    // Request port.
    input  wire logic                   req_valid,
    input  wire dsdr_pkg::dsdr_cmd_type req_cmd,
    input  wire logic [1:0]             req_bank,
    input  wire logic [11:0]            req_addr,
    input  wire logic [63:0]            req_wdata,
    input  wire logic [7:0]             req_wmask,
    input  wire logic                   cke_req,
    output wire logic                   req_ready,
    // Read return.
    output wire logic [63:0]            rd_data,
    output wire logic                   rd_valid
);

    typedef struct packed {
        logic [2:0]  cnt;
        logic        clk;
        logic        clk_n;
        logic        cke;
        logic [3:0]  cmd;
        logic [1:0]  bank;
        logic [11:0] addr;
        logic        ready;
        logic        pend;
        logic [3:0]  p_cmd;
        logic [1:0]  p_bank;
        logic [11:0] p_addr;
        logic [63:0] p_data;
        logic [7:0]  p_mask;
        logic        wr_busy;
        logic [4:0]  wr_t;
        logic [3:0]  mask;
        logic [31:0] dq_out;
        logic        dq_oe;
        logic [3:0]  dqs_out;
        logic        dqs_oe;
        logic [32:0] s1;
        logic [32:0] s2;
        logic        dqs_q;
        logic        rd_wait;
        logic        rd_got;
        logic [63:0] rdata;
        logic        rvalid;
    } dsdr_ctl_state_type;

    dsdr_ctl_state_type st;
    dsdr_ctl_state_type next_st;

    always_comb begin
        next_st = st;
        next_st.cnt = st.cnt + 3'h1;
        next_st.s1 = {link.data_strobe_lanes[0], link.data_bus};
        next_st.s2 = st.s1;
        next_st.dqs_q = st.s2[32];
        next_st.rvalid = 1'b0;
        if (st.cnt == dsdr_pkg::DSDR_CNT_RISE) begin
            next_st.clk = 1'b1;
            next_st.clk_n = 1'b0;
        end
        if (st.cnt == dsdr_pkg::DSDR_CNT_FALL) begin
            // Command pins change at the fall, centred on the sampling rise.
            next_st.clk = 1'b0;
            next_st.clk_n = 1'b1;
            next_st.cke = cke_req;
            next_st.cmd = dsdr_pkg::DSDR_CMD_NOP;
            if (st.pend) begin
                next_st.pend = 1'b0;
                next_st.cmd = st.p_cmd;
                next_st.bank = st.p_bank;
                next_st.addr = st.p_addr;
                if (st.p_cmd == dsdr_pkg::DSDR_CMD_WRITE) begin
                    next_st.wr_busy = 1'b1;
                    next_st.wr_t = 5'h00;
                end
                if (st.p_cmd == dsdr_pkg::DSDR_CMD_READ) begin
                    next_st.rd_wait = 1'b1;
                    next_st.rd_got = 1'b0;
                end
            end
        end

        // Write burst: data on clock crossings, strobe centred between them.
        if (st.wr_busy) begin
            next_st.wr_t = st.wr_t + 5'h01;
            case (next_st.wr_t)
                dsdr_pkg::DSDR_WR_WORD0_T: begin
                    next_st.dq_out = st.p_data[31:0];
                    next_st.mask = st.p_mask[3:0];
                    next_st.dq_oe = 1'b1;
                    next_st.dqs_out = 4'h0;
                    next_st.dqs_oe = 1'b1;
                end
                dsdr_pkg::DSDR_WR_STB_UP_T: next_st.dqs_out = 4'hF;
                dsdr_pkg::DSDR_WR_WORD1_T: begin
                    next_st.dq_out = st.p_data[63:32];
                    next_st.mask = st.p_mask[7:4];
                end
                dsdr_pkg::DSDR_WR_STB_DN_T: next_st.dqs_out = 4'h0;
                dsdr_pkg::DSDR_WR_END_T: begin
                    next_st.dq_oe = 1'b0;
                    next_st.dqs_oe = 1'b0;
                    next_st.mask = 4'h0;
                    next_st.wr_busy = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // Read return: data is taken as the synchronised strobe changes.
        if (st.rd_wait) begin
            if (st.s2[32] && !st.dqs_q && !st.rd_got) begin
                next_st.rdata[31:0] = st.s2[31:0];
                next_st.rd_got = 1'b1;
            end else if (!st.s2[32] && st.dqs_q && st.rd_got) begin
                next_st.rdata[63:32] = st.s2[31:0];
                next_st.rvalid = 1'b1;
                next_st.rd_wait = 1'b0;
            end
        end

        if (st.ready && req_valid) begin
            next_st.pend = 1'b1;
            next_st.p_cmd = req_cmd;
            next_st.p_bank = req_bank;
            next_st.p_addr = req_addr;
            next_st.p_data = req_wdata;
            next_st.p_mask = req_wmask;
        end
        next_st.ready = !next_st.pend && !next_st.wr_busy && !next_st.rd_wait;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.cmd <= dsdr_pkg::DSDR_CMD_DESEL;
            st.clk_n <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign link.diff_clock       = st.clk;
    assign link.diff_clock_n     = st.clk_n;
    assign link.cke              = st.cke;
    assign link.cs_n             = st.cmd[3];
    assign link.ras_n            = st.cmd[2];
    assign link.cas_n            = st.cmd[1];
    assign link.we_n             = st.cmd[0];
    assign link.bank_select      = st.bank;
    assign link.addr             = st.addr;
    assign link.write_mask_lanes = st.mask;
    assign link.ctl_data_out     = st.dq_out;
    assign link.ctl_data_oe      = st.dq_oe;
    assign link.ctl_strobe_out   = st.dqs_out;
    assign link.ctl_strobe_oe    = st.dqs_oe;
    assign req_ready             = st.ready;
    assign rd_data               = st.rdata;
    assign rd_valid              = st.rvalid;

endmodule

// ==== test/dsdr_link_chk.sv ====
`timescale 1ns/1ns
module dsdr_link_chk (
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Link control.
    input wire logic        diff_clock,
    input wire logic        diff_clock_n,
    input wire logic        cke,
    input wire logic        cs_n,
    input wire logic        ras_n,
    input wire logic        cas_n,
    input wire logic        we_n,
    // Data lanes.
    input wire logic        ctl_data_oe,
    input wire logic [3:0]  ctl_strobe_out,
    input wire logic        ctl_strobe_oe,
    input wire logic [31:0] dev_data_out,
    input wire logic        dev_data_oe,
    input wire logic [3:0]  dev_strobe_out,
    input wire logic        dev_strobe_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // The first command and enable update after reset comes before any link rise.
    logic link_live;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            link_live <= 1'b0;
        end else if (diff_clock) begin
            link_live <= 1'b1;
        end
    end

    a_clk_pair_opposite: assert property (diff_clock_n == !diff_clock)
        else $error("link clock pair not complementary");
    a_link_clock_period: assert property (
        $rose(diff_clock) |-> ##8 $rose(diff_clock))
        else $error("link clock period wrong");
    a_cmd_at_fall: assert property (
        link_live && $changed({cs_n, ras_n, cas_n, we_n}) |-> $fell(diff_clock))
        else $error("command changed off a link fall");
    a_cke_at_fall: assert property (
        link_live && $changed(cke) |-> $fell(diff_clock))
        else $error("clock enable changed off a link fall");
    a_one_bus_driver: assert property (
        !(ctl_data_oe && dev_data_oe) && !(ctl_strobe_oe && dev_strobe_oe))
        else $error("both ends drive the bus");
    a_wr_strobe_centred: assert property (
        $rose(ctl_strobe_oe) |->
        ctl_strobe_out == 4'h0 ##2 ctl_strobe_out == 4'hF ##4 ctl_strobe_out == 4'h0)
        else $error("write strobe not centred");
    a_wr_burst_length: assert property (
        $rose(ctl_data_oe) |-> ctl_data_oe [*8] ##1 !ctl_data_oe)
        else $error("write burst length wrong");
    a_rd_edge_aligned: assert property (
        dev_data_oe && $past(dev_data_oe) && $changed(dev_data_out) |->
        $changed(dev_strobe_out))
        else $error("read data moved without strobe");
    a_rd_preamble: assert property (
        $rose(dev_strobe_oe) |->
        !dev_data_oe ##[6:10] ($rose(dev_data_oe) && dev_strobe_out == 4'hF))
        else $error("read preamble wrong");
endmodule

// ==== test/dsdr_bench.sv ====
`timescale 1ns/1ns
module dsdr_bench;
    logic                   ref_clk;
    logic                   rst_n;
    logic                   req_valid;
    dsdr_pkg::dsdr_cmd_type req_cmd;
    logic [1:0]             req_bank;
    logic [11:0]            req_addr;
    logic [63:0]            req_wdata;
    logic [7:0]             req_wmask;
    logic                   cke_req;
    logic                   req_ready;
    logic [63:0]            rd_data;
    logic                   rd_valid;
    logic                   power_down;
    logic                   self_refresh;
    logic [3:0]             open_banks;
    logic [63:0]            got;
    int                     miscompares = 0;
    int                     total_checks = 0;
    int                     cycles = 0;

    dsdr_link_if link ();
    dsdr_controller i_dsdr_controller (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .link(link),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_wmask(req_wmask), .cke_req(cke_req),
        .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid));
    dsdr_device i_dsdr_device (.ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .link(link),
        .power_down(power_down), .self_refresh(self_refresh), .open_banks(open_banks));
    dsdr_link_chk i_dsdr_link_chk (.ref_clk(ref_clk), .rst_n(rst_n),
        .diff_clock(link.diff_clock), .diff_clock_n(link.diff_clock_n), .cke(link.cke),
        .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .ctl_data_oe(link.ctl_data_oe), .ctl_strobe_out(link.ctl_strobe_out),
        .ctl_strobe_oe(link.ctl_strobe_oe), .dev_data_out(link.dev_data_out),
        .dev_data_oe(link.dev_data_oe), .dev_strobe_out(link.dev_strobe_out),
        .dev_strobe_oe(link.dev_strobe_oe));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Issues one request, then waits until the controller is ready again,
    // keeping any read data that comes back meanwhile.
    task automatic send(dsdr_pkg::dsdr_cmd_type c, logic [1:0] b, logic [11:0] a,
                        logic [63:0] d, logic [7:0] m, logic k);
        int n;
        @(negedge ref_clk);
        while (req_ready !== 1'b1) @(negedge ref_clk);
        req_valid = 1'b1;
        req_cmd = c;
        req_bank = b;
        req_addr = a;
        req_wdata = d;
        req_wmask = m;
        cke_req = k;
        @(negedge ref_clk);
        req_valid = 1'b0;
        for (n = 0; n < 80 && (n < 3 || req_ready !== 1'b1); n++) begin
            @(negedge ref_clk);
            if (rd_valid === 1'b1) got = rd_data;
        end
    endtask

    // Waits a bounded time for {power_down, self_refresh, open_banks}.
    task automatic expect_state(string what, logic [5:0] exp);
        int n;
        for (n = 0; n < 40 && {power_down, self_refresh, open_banks} !== exp; n++)
            @(negedge ref_clk);
        check(what, 64'({power_down, self_refresh, open_banks}), 64'(exp));
    endtask

    task automatic test_banks();
        send(dsdr_pkg::DSDR_CMD_ACT, 2'h1, 12'h005, 64'h0, 8'h00, 1'b1);
        expect_state("open bank 1", 6'h02);
        send(dsdr_pkg::DSDR_CMD_ACT, 2'h3, 12'h000, 64'h0, 8'h00, 1'b1);
        expect_state("open bank 3", 6'h0A);
        // A precharge-all code with chip select high must leave both rows open.
        send(dsdr_pkg::dsdr_cmd_type'(4'hA), 2'h1, 12'h400, 64'h0, 8'h00, 1'b1);
        repeat (16) @(negedge ref_clk);
        expect_state("deselected", 6'h0A);
        send(dsdr_pkg::DSDR_CMD_PRE, 2'h3, 12'h000, 64'h0, 8'h00, 1'b1);
        expect_state("close bank 3", 6'h02);
        $display("test banks done");
    endtask

    task automatic test_data();
        send(dsdr_pkg::DSDR_CMD_WRITE, 2'h1, 12'h002, 64'h0123_4567_89AB_CDEF, 8'h00, 1'b1);
        send(dsdr_pkg::DSDR_CMD_WRITE, 2'h1, 12'h002, 64'hFEDC_BA98_7654_3210, 8'h21, 1'b1);
        send(dsdr_pkg::DSDR_CMD_READ, 2'h1, 12'h002, 64'h0, 8'h00, 1'b1);
        check("masked read", got, 64'hFEDC_4598_7654_32EF);
        send(dsdr_pkg::DSDR_CMD_WRITE, 2'h1, 12'h005, 64'h1111_2222_3333_4444, 8'h00, 1'b1);
        send(dsdr_pkg::DSDR_CMD_READ, 2'h1, 12'h005, 64'h0, 8'h00, 1'b1);
        check("odd column read", got, 64'h1111_2222_3333_4444);
        send(dsdr_pkg::DSDR_CMD_READ, 2'h1, 12'h402, 64'h0, 8'h00, 1'b1);
        check("precharge read", got, 64'hFEDC_4598_7654_32EF);
        expect_state("auto precharge", 6'h00);
        $display("test data done");
    endtask

    task automatic test_power();
        send(dsdr_pkg::DSDR_CMD_ACT, 2'h0, 12'h000, 64'h0, 8'h00, 1'b1);
        cke_req = 1'b0;
        expect_state("active power-down", 6'h21);
        cke_req = 1'b1;
        expect_state("power-down exit", 6'h01);
        send(dsdr_pkg::DSDR_CMD_PRE, 2'h0, 12'h400, 64'h0, 8'h00, 1'b1);
        cke_req = 1'b0;
        expect_state("precharge power-down", 6'h20);
        send(dsdr_pkg::DSDR_CMD_ACT, 2'h2, 12'h000, 64'h0, 8'h00, 1'b0);
        repeat (16) @(negedge ref_clk);
        expect_state("ignored in power-down", 6'h20);
        cke_req = 1'b1;
        expect_state("precharge exit", 6'h00);
        send(dsdr_pkg::DSDR_CMD_REFRESH, 2'h0, 12'h000, 64'h0, 8'h00, 1'b0);
        expect_state("self refresh", 6'h10);
        cke_req = 1'b1;
        expect_state("self refresh exit", 6'h00);
        send(dsdr_pkg::DSDR_CMD_ACT, 2'h2, 12'h000, 64'h0, 8'h00, 1'b1);
        expect_state("awake again", 6'h04);
        $display("test power done");
    endtask

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_cmd = dsdr_pkg::DSDR_CMD_NOP;
        req_bank = 2'h0;
        req_addr = 12'h000;
        req_wdata = 64'h0;
        req_wmask = 8'h00;
        cke_req = 1'b1;
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        test_banks();
        test_data();
        test_power();
        print_verdict();
    end
endmodule
